// ### common/cpr_pkg.sv
// Package for the colour and proximity result readout block
package cpr_pkg;

    // Register addresses of the result bytes
    localparam logic [7:0] CPR_ADDR_CLEAR_LOW = 8'h14;
    localparam logic [7:0] CPR_ADDR_CLEAR_HIGH = 8'h15;
    localparam logic [7:0] CPR_ADDR_RED_LOW = 8'h16;
    localparam logic [7:0] CPR_ADDR_RED_HIGH = 8'h17;
    localparam logic [7:0] CPR_ADDR_GREEN_LOW = 8'h18;
    localparam logic [7:0] CPR_ADDR_GREEN_HIGH = 8'h19;
    localparam logic [7:0] CPR_ADDR_BLUE_LOW = 8'h1a;
    localparam logic [7:0] CPR_ADDR_BLUE_HIGH = 8'h1b;
    localparam logic [7:0] CPR_ADDR_PROX_LOW = 8'h1c;
    localparam logic [7:0] CPR_ADDR_PROX_HIGH = 8'h1d;
    localparam logic [7:0] CPR_ADDR_FIRST = 8'h14;

    // Channel count and indices
    localparam int CPR_NUM_CHAN = 5;
    localparam logic [2:0] CPR_CH_CLEAR = 3'h0;
    localparam logic [2:0] CPR_CH_RED = 3'h1;
    localparam logic [2:0] CPR_CH_GREEN = 3'h2;
    localparam logic [2:0] CPR_CH_BLUE = 3'h3;
    localparam logic [2:0] CPR_CH_PROX = 3'h4;

    // Reset values
    localparam logic [15:0] CPR_RESULT_RESET = 16'h0000;
    localparam logic [7:0] CPR_SHADOW_RESET = 8'h00;
    localparam logic [7:0] CPR_UNMAPPED_DATA = 8'h00;

    // Field layout of a 16-bit result
    localparam int CPR_LOW_LSB = 0;
    localparam int CPR_HIGH_LSB = 8;

    // Register read request from the serial front end
    typedef struct packed {
        logic strobe;
        logic [7:0] addr;
    } cpr_rd_req_t;

    // Conversion-complete update for colour channels and proximity
    typedef struct packed {
        logic colourValid;
        logic [15:0] clearVal;
        logic [15:0] redVal;
        logic [15:0] greenVal;
        logic [15:0] blueVal;
        logic proxValid;
        logic [15:0] proxVal;
    } cpr_conv_t;

endpackage

// ### core/cpr_readout.sv
// Result readout registers of the colour and proximity sensor
// Function
// - Clear, red, green, blue results each held as 16 bits, low and high byte.
// - Proximity result held as 16 bits, exposed as low and high byte.
// - Reading any low byte copies that result's upper byte into its shadow.
// - High byte read returns the shadow even after newer conversions land.
// - Colour bytes at 0x14 to 0x1b, clear red green blue, low byte even.
// - Proximity low byte at 0x1c, high byte at 0x1d, both readable.
`timescale 1ns/1ps
module cpr_readout
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register read port from the serial front end
    input wire cpr_rd_req_t rdReq,
    output logic [7:0] rdData,
    output logic rdHit,
    // Conversion results
    input wire cpr_conv_t conv
);

    // Where a byte read lands: channel and byte half
    typedef struct packed {
        logic hit;
        logic high;
        logic [2:0] chan;
    } cpr_dec_t;

    typedef struct packed {
        logic [7:0] rdData;
        logic rdHit;
    } cpr_rd_state_t;

    cpr_rd_state_t state_q;
    cpr_rd_state_t state_d;
    cpr_dec_t dec;

    // Colour channels integrate together, so one strobe loads all four
    logic colourUpd;
    logic proxUpd;

    // Live words, updated by conversions
    logic [15:0] clearLive;
    logic [15:0] redLive;
    logic [15:0] greenLive;
    logic [15:0] blueLive;
    logic [15:0] proxLive;

    // Frozen high bytes, updated by low reads
    logic [7:0] clearShadow;
    logic [7:0] redShadow;
    logic [7:0] greenShadow;
    logic [7:0] blueShadow;
    logic [7:0] proxShadow;

    // One-cycle low-byte read strobes
    logic clearLowRead;
    logic redLowRead;
    logic greenLowRead;
    logic blueLowRead;
    logic proxLowRead;

    // Candidate answer bytes
    logic [7:0] lowByte;
    logic [7:0] highByte;

    assign colourUpd = conv.colourValid;
    assign proxUpd = conv.proxValid;

    // Full address compare, no base subtraction, so wrap-around
    // addresses below the map can never alias into it
    // colour and proximity byte pairs
    always_comb begin
        dec.hit = 1'b0;
        dec.high = 1'b0;
        dec.chan = CPR_CH_CLEAR;
        unique case (rdReq.addr)
            CPR_ADDR_CLEAR_LOW: begin
                dec.hit = 1'b1;
                dec.high = 1'b0;
                dec.chan = CPR_CH_CLEAR;
            end
            CPR_ADDR_CLEAR_HIGH: begin
                dec.hit = 1'b1;
                dec.high = 1'b1;
                dec.chan = CPR_CH_CLEAR;
            end
            CPR_ADDR_RED_LOW: begin
                dec.hit = 1'b1;
                dec.high = 1'b0;
                dec.chan = CPR_CH_RED;
            end
            CPR_ADDR_RED_HIGH: begin
                dec.hit = 1'b1;
                dec.high = 1'b1;
                dec.chan = CPR_CH_RED;
            end
            CPR_ADDR_GREEN_LOW: begin
                dec.hit = 1'b1;
                dec.high = 1'b0;
                dec.chan = CPR_CH_GREEN;
            end
            CPR_ADDR_GREEN_HIGH: begin
                dec.hit = 1'b1;
                dec.high = 1'b1;
                dec.chan = CPR_CH_GREEN;
            end
            CPR_ADDR_BLUE_LOW: begin
                dec.hit = 1'b1;
                dec.high = 1'b0;
                dec.chan = CPR_CH_BLUE;
            end
            CPR_ADDR_BLUE_HIGH: begin
                dec.hit = 1'b1;
                dec.high = 1'b1;
                dec.chan = CPR_CH_BLUE;
            end
            CPR_ADDR_PROX_LOW: begin
                dec.hit = 1'b1;
                dec.high = 1'b0;
                dec.chan = CPR_CH_PROX;
            end
            CPR_ADDR_PROX_HIGH: begin
                dec.hit = 1'b1;
                dec.high = 1'b1;
                dec.chan = CPR_CH_PROX;
            end
            default: begin
                dec.hit = 1'b0;
            end
        endcase
    end

    // Word mode is decided outside; every low read freezes its shadow
    // low read decode
    always_comb begin
        clearLowRead = 1'b0;
        redLowRead = 1'b0;
        greenLowRead = 1'b0;
        blueLowRead = 1'b0;
        proxLowRead = 1'b0;
        if (rdReq.strobe && dec.hit && !dec.high) begin
            unique case (dec.chan)
                CPR_CH_CLEAR: begin
                    clearLowRead = 1'b1;
                end
                CPR_CH_RED: begin
                    redLowRead = 1'b1;
                end
                CPR_CH_GREEN: begin
                    greenLowRead = 1'b1;
                end
                CPR_CH_BLUE: begin
                    blueLowRead = 1'b1;
                end
                CPR_CH_PROX: begin
                    proxLowRead = 1'b1;
                end
                default: begin
                    clearLowRead = 1'b0;
                end
            endcase
        end
    end

    cpr_result_slot u_clear (
        .clk(clk),
        .rst_b(rst_b),
        .update(colourUpd),
        .updateVal(conv.clearVal),
        .lowRead(clearLowRead),
        .live(clearLive),
        .shadow(clearShadow)
    );

    cpr_result_slot u_red (
        .clk(clk),
        .rst_b(rst_b),
        .update(colourUpd),
        .updateVal(conv.redVal),
        .lowRead(redLowRead),
        .live(redLive),
        .shadow(redShadow)
    );

    cpr_result_slot u_green (
        .clk(clk),
        .rst_b(rst_b),
        .update(colourUpd),
        .updateVal(conv.greenVal),
        .lowRead(greenLowRead),
        .live(greenLive),
        .shadow(greenShadow)
    );

    cpr_result_slot u_blue (
        .clk(clk),
        .rst_b(rst_b),
        .update(colourUpd),
        .updateVal(conv.blueVal),
        .lowRead(blueLowRead),
        .live(blueLive),
        .shadow(blueShadow)
    );

    cpr_result_slot u_prox (
        .clk(clk),
        .rst_b(rst_b),
        .update(proxUpd),
        .updateVal(conv.proxVal),
        .lowRead(proxLowRead),
        .live(proxLive),
        .shadow(proxShadow)
    );

    // Low bytes come straight from the live word
    always_comb begin
        lowByte = CPR_UNMAPPED_DATA;
        unique case (dec.chan)
            CPR_CH_CLEAR: begin
                lowByte = clearLive[CPR_LOW_LSB +: 8];
            end
            CPR_CH_RED: begin
                lowByte = redLive[CPR_LOW_LSB +: 8];
            end
            CPR_CH_GREEN: begin
                lowByte = greenLive[CPR_LOW_LSB +: 8];
            end
            CPR_CH_BLUE: begin
                lowByte = blueLive[CPR_LOW_LSB +: 8];
            end
            CPR_CH_PROX: begin
                lowByte = proxLive[CPR_LOW_LSB +: 8];
            end
            default: begin
                lowByte = CPR_UNMAPPED_DATA;
            end
        endcase
    end

    // High bytes never come from the live word, which may have moved on
    always_comb begin
        highByte = CPR_UNMAPPED_DATA;
        unique case (dec.chan)
            CPR_CH_CLEAR: begin
                highByte = clearShadow;
            end
            CPR_CH_RED: begin
                highByte = redShadow;
            end
            CPR_CH_GREEN: begin
                highByte = greenShadow;
            end
            CPR_CH_BLUE: begin
                highByte = blueShadow;
            end
            CPR_CH_PROX: begin
                highByte = proxShadow;
            end
            default: begin
                highByte = CPR_UNMAPPED_DATA;
            end
        endcase
    end

    // Answer registered, one cycle after the strobe
    always_comb begin
        state_d = state_q;
        state_d.rdHit = 1'b0;
        if (rdReq.strobe) begin
            state_d.rdHit = dec.hit;
            state_d.rdData = CPR_UNMAPPED_DATA;
            if (dec.hit && dec.high) begin
                state_d.rdData = highByte;
            end else if (dec.hit) begin
                state_d.rdData = lowByte;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{rdData: CPR_UNMAPPED_DATA, rdHit: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign rdHit = state_q.rdHit;

endmodule

// ### core/cpr_result_slot.sv
// One result channel: live word and high-byte shadow
`timescale 1ns/1ps
module cpr_result_slot
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Conversion update
    input wire logic update,
    input wire logic [15:0] updateVal,
    // Host read of this channel's low byte
    input wire logic lowRead,
    // Contents
    output logic [15:0] live,
    output logic [7:0] shadow
);

    typedef struct packed {
        logic [15:0] live;
        logic [7:0] shadow;
    } cpr_slot_state_t;

    cpr_slot_state_t state_q;
    cpr_slot_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (update) begin
            state_d.live = updateVal;
        end
        if (lowRead) begin
            state_d.shadow = state_q.live[CPR_HIGH_LSB +: 8];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{live: CPR_RESULT_RESET, shadow: CPR_SHADOW_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign live = state_q.live;
    assign shadow = state_q.shadow;

endmodule

// ### tb/cpr_host.sv
// Host model issuing byte reads
`timescale 1ns/1ps
module cpr_host
    import cpr_pkg::*;
(
    // Bus side
    input wire logic clk,
    input wire logic [7:0] rdData,
    output cpr_rd_req_t rdReq
);
    initial rdReq = '0;
    // Address flipped on release so stale values never match
    task automatic rd(input logic [7:0] x, output logic [7:0] d);
        @(posedge clk) #1 rdReq = {1'b1, x};
        @(posedge clk) #1 rdReq = {1'b0, ~x};
        d = rdData;
    endtask
endmodule

// ### tb/cpr_readout_sva.sv
// Port assertions for the result readout
`timescale 1ns/1ps
module cpr_readout_sva
    import cpr_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic rst_b,
    input wire cpr_rd_req_t rdReq,
    input wire logic [7:0] rdData,
    input wire logic rdHit,
    input wire cpr_conv_t conv
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] c_q;
    logic [7:0] cs_q;
    logic [15:0] p_q;
    wire logic r = rdReq.strobe;
    wire logic [7:0] a = rdReq.addr;
    wire logic m = a inside {[8'h14:8'h1d]};
    // Clear channel and proximity word only, to keep the helper small
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c_q <= '0;
            cs_q <= '0;
            p_q <= '0;
        end else begin
            if (conv.colourValid) c_q <= conv.clearVal;
            if (conv.proxValid) p_q <= conv.proxVal;
            if (r && a == 8'h14) cs_q <= c_q[15:8];
        end
    end
    property p_hit; r && m |=> rdHit; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_miss; r && !m |=> !rdHit && rdData == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("bad hit");
    property p_idle; !r |=> !rdHit && $stable(rdData); endproperty
    a_idle: assert property (p_idle) else $error("moved");
    property p_cl; r && a == 8'h14 |=> rdData == $past(c_q[7:0]); endproperty
    a_cl: assert property (p_cl) else $error("clear low");
    property p_ch; r && a == 8'h15 |=> rdData == $past(cs_q); endproperty
    a_ch: assert property (p_ch) else $error("clear high");
    property p_pl; r && a == 8'h1c |=> rdData == $past(p_q[7:0]); endproperty
    a_pl: assert property (p_pl) else $error("prox low");
    c_word: cover property (r && a == 8'h14 ##2 r && a == 8'h15);
    c_upd: cover property (conv.colourValid);
    c_miss: cover property (r && !m);
endmodule

// ### tb/tb.sv
// Self-checking bench for the result readout
`timescale 1ns/1ps
module tb;
    import cpr_pkg::*;
    logic clk, rst_b;
    cpr_rd_req_t rdReq;
    cpr_conv_t conv;
    logic [7:0] rdData, lo, hi;
    logic hit;
    logic [15:0] u, v[5];
    int n_mismatch, n_checks, cyc;
    cpr_readout dut_u(.clk(clk), .rst_b(rst_b), .rdReq(rdReq), .rdData(rdData), .rdHit(hit),
        .conv(conv));
    cpr_host host_u(.clk(clk), .rdData(rdData), .rdReq(rdReq));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (++cyc > 4000) test_done(1);
    function automatic logic [7:0] hb(logic [15:0] x);
        return x[15:8];
    endfunction
    task automatic chk(input logic [7:0] s, e, input string nm);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic load;
        @(posedge clk) #1 conv = {1'b1, v[0], v[1], v[2], v[3], 1'b1, v[4]};
        @(posedge clk) #1 conv = '0;
    endtask
    task automatic test_done(input int to);
        n_mismatch += to;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        conv = '0;
        rst_b = 0;
        void'($urandom(32'h031f));
        repeat (5) @(posedge clk);
        #1 rst_b = 1;
        host_u.rd(8'h1d, hi);
        chk(hi, CPR_SHADOW_RESET, "fresh shadow");
        chk({7'h00, hit}, 8'h01, "hit");
        host_u.rd(8'h1e, lo);
        chk(lo, CPR_UNMAPPED_DATA, "unmapped");
        chk({7'h00, hit}, 8'h00, "miss");
        for (int k = 0; k < 40; k++) begin
            foreach (v[i]) v[i] = k ? 16'($urandom) : 16'hff00 >> i;
            load();
            for (int c = 0; c < 5; c++) begin
                u = v[c];
                host_u.rd(8'h14 + 8'(2 * c), lo);
                if (k[0]) begin
                    foreach (v[i]) v[i] = 16'($urandom);
                    load();
                end
                host_u.rd(8'h15 + 8'(2 * c), hi);
                chk(lo, u[7:0], "low byte");
                chk(hi, hb(u), "high byte");
                chk({7'h00, hit}, 8'h01, "word hit");
            end
        end
        test_done(0);
    end
endmodule
bind cpr_readout cpr_readout_sva chk_u(.clk(clk), .rst_b(rst_b), .rdReq(rdReq),
    .rdData(rdData), .rdHit(rdHit), .conv(conv));
